// [hdl/i2c_timing_pkg.sv]
// Constants, field layouts and types for the two-wire timing and mask block.
package i2c_timing_pkg;

  localparam logic [7:0] TIMER_PERIOD_OFFSET = 8'h0C;
  localparam logic [7:0] MASK_OFFSET = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;
  localparam logic [7:0] MASKED_OFFSET = 8'h18;
  localparam logic [7:0] CONTROL_OFFSET = 8'h1C;

  localparam logic [6:0] PERIOD_RESET = 7'h01;
  localparam logic [6:0] PERIOD_MIN = 7'h01;
  localparam logic [2:0] FILTER_RESET = 3'h0;
  localparam logic [11:0] MASK_RESET = 12'h000;
  localparam logic [11:0] STATUS_RESET = 12'h000;
  localparam logic CLOCK_RUN_RESET = 1'b0;

  localparam logic [3:0] LOW_PHASE_COUNT = 4'h6;
  localparam logic [3:0] HIGH_PHASE_COUNT = 4'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [12:0] reserved_hi;
    logic [2:0] glitch_filter_width;
    logic [8:0] reserved_lo;
    logic [6:0] clock_period_value;
  } timer_period_t;

  typedef struct packed {
    logic rx_full;
    logic tx_empty;
    logic rx_request;
    logic tx_request;
    logic arbitration_loss;
    logic stop_detect;
    logic start_detect;
    logic no_ack;
    logic tx_dma_done;
    logic rx_dma_done;
    logic clock_timeout;
    logic general_master;
  } irq_vec_t;

  // Filter length in system clocks for each width code.
  function automatic logic [4:0] filter_clocks(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h00;
    unique case (code)
      3'h0: n = 5'h00;
      3'h1: n = 5'h01;
      3'h2: n = 5'h02;
      3'h3: n = 5'h03;
      3'h4: n = 5'h04;
      3'h5: n = 5'h08;
      3'h6: n = 5'h10;
      3'h7: n = 5'h1F;
    endcase
    return n;
  endfunction : filter_clocks

endpackage : i2c_timing_pkg

// [hdl/i2c_master_timing_irq.sv]
// SCL clock generator, input glitch filters and masked interrupt registers.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module i2c_master_timing_irq
  import i2c_timing_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Two-wire lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic scl_filtered,
  output logic sda_filtered,
  // Raw conditions from the master core, one-cycle pulses
  input wire irq_vec_t raw_events,
  // Interrupt
  output logic irq
);

  typedef enum logic [1:0] {
    SCL_IDLE,
    SCL_LOW,
    SCL_HIGH
  } scl_state_t;

  timer_period_t timer_period;
  irq_vec_t mask;
  irq_vec_t status;
  irq_vec_t masked;
  logic clock_run;

  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic do_read;
  logic status_read;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic werr;

  logic [1:0] line_in;
  logic [1:0] sync_a;
  logic [1:0] sync_b;
  logic [1:0] filt_out;
  logic [4:0] filt_len;

  scl_state_t scl_state;
  logic [7:0] div_cnt;
  logic [7:0] div_limit;
  logic unit_tick;
  logic [3:0] phase_cnt;

  // Write channel: address and data are taken independently and held.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_addr)
      TIMER_PERIOD_OFFSET, MASK_OFFSET, STATUS_OFFSET,
      MASKED_OFFSET, CONTROL_OFFSET: werr = 1'b0;
      default: werr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= werr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // A period value of zero is out of range and leaves the field unchanged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_period <= '0;
      timer_period.clock_period_value <= PERIOD_RESET;
      timer_period.glitch_filter_width <= FILTER_RESET;
    end else if (do_write && aw_addr == TIMER_PERIOD_OFFSET) begin
      if (w_strb[2]) begin
        timer_period.glitch_filter_width <= w_data[18:16];
      end
      if (w_strb[0] && w_data[6:0] >= PERIOD_MIN) begin
        timer_period.clock_period_value <= w_data[6:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= MASK_RESET;
    end else if (do_write && aw_addr == MASK_OFFSET) begin
      if (w_strb[0]) begin
        mask[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        mask[11:8] <= w_data[11:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clock_run <= CLOCK_RUN_RESET;
    end else if (do_write && aw_addr == CONTROL_OFFSET && w_strb[0]) begin
      clock_run <= w_data[0];
    end
  end

  // Read channel: one read at a time, answered the cycle after address.
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign status_read = do_read && s_axi_araddr == STATUS_OFFSET;

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    unique case (s_axi_araddr)
      TIMER_PERIOD_OFFSET: next_rdata = timer_period;
      MASK_OFFSET: next_rdata = {20'h0_0000, mask};
      STATUS_OFFSET: next_rdata = {20'h0_0000, status};
      MASKED_OFFSET: next_rdata = {20'h0_0000, masked};
      CONTROL_OFFSET: next_rdata = {31'h0000_0000, clock_run};
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky status: a read clears it, but an event in that cycle survives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= STATUS_RESET;
    end else begin
      status <= (status_read ? STATUS_RESET : status) | raw_events;
    end
  end

  assign masked = status & mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |masked;
    end
  end

  // Line inputs: two-flop synchroniser, then a stability filter per line.
  assign line_in = {sda_in, scl_in};
  assign filt_len = filter_clocks(timer_period.glitch_filter_width);

  generate
    for (genvar i = 0; i < 2; i++) begin : g_line
      logic [4:0] stable_cnt;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_a[i] <= 1'b1;
          sync_b[i] <= 1'b1;
        end else begin
          sync_a[i] <= line_in[i];
          sync_b[i] <= sync_a[i];
        end
      end

      // A new level is passed once it has held for the filter length.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          filt_out[i] <= 1'b1;
          stable_cnt <= 5'h00;
        end else if (filt_len == 5'h00 || sync_b[i] == filt_out[i]) begin
          filt_out[i] <= sync_b[i];
          stable_cnt <= 5'h00;
        end else if (stable_cnt + 5'h01 >= filt_len) begin
          filt_out[i] <= sync_b[i];
          stable_cnt <= 5'h00;
        end else begin
          stable_cnt <= stable_cnt + 5'h01;
        end
      end
    end
  endgenerate

  assign scl_filtered = filt_out[0];
  assign sda_filtered = filt_out[1];

  // Unit divider: one tick every 2*(1+period value) system clocks.
  assign div_limit = {timer_period.clock_period_value, 1'b1};
  assign unit_tick = div_cnt == div_limit;

  always_ff @(posedge aclk) begin
    if (!aresetn || scl_state == SCL_IDLE || unit_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // SCL generator: six units low, four units high, while enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_state <= SCL_IDLE;
      phase_cnt <= 4'h0;
    end else begin
      unique case (scl_state)
        SCL_IDLE: begin
          phase_cnt <= 4'h0;
          if (clock_run) begin
            scl_state <= SCL_LOW;
          end
        end
        SCL_LOW: begin
          if (unit_tick) begin
            if (phase_cnt == LOW_PHASE_COUNT - 4'h1) begin
              phase_cnt <= 4'h0;
              scl_state <= SCL_HIGH;
            end else begin
              phase_cnt <= phase_cnt + 4'h1;
            end
          end
        end
        SCL_HIGH: begin
          if (unit_tick) begin
            if (phase_cnt == HIGH_PHASE_COUNT - 4'h1) begin
              phase_cnt <= 4'h0;
              scl_state <= clock_run ? SCL_LOW : SCL_IDLE;
            end else begin
              phase_cnt <= phase_cnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Open-drain SCL: the pin is only ever pulled low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe <= scl_state == SCL_LOW;
    end
  end

endmodule : i2c_master_timing_irq

// [test/i2c_master_timing_irq_checker.sv]
// Assertions on the register bus, interrupt and SCL drive.
`timescale 1ns/1ps
module i2c_master_timing_irq_checker
  import i2c_timing_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line drive and interrupt
  input wire logic scl_oe,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] run;
  logic [15:0] pull;
  logic oe_q;
  // Run holds the length of the level that scl_oe has just left.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run <= 16'h0000;
      oe_q <= 1'b0;
    end else begin
      oe_q <= scl_oe;
      run <= (scl_oe != oe_q) ? 16'h0001 : run + 16'h0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pull <= 16'h0000;
    end else if (oe_q && !scl_oe) begin
      pull <= run;
    end
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  irq_reset_a: assert property ($rose(aresetn) |-> (!irq) [*2])
    else $error("interrupt high after reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  aw_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  pull_len_a: assert property ($fell(scl_oe)
    |-> run >= 16'h0018 && run % 16'h000C == 16'h0000)
    else $error("SCL low phase length wrong");
  phase_ratio_a: assert property ($rose(scl_oe) && run < pull
    |-> run * 16'h0003 == pull * 16'h0002)
    else $error("SCL high to low ratio wrong");
endmodule : i2c_master_timing_irq_checker
bind i2c_master_timing_irq i2c_master_timing_irq_checker checker_i (.*);

// [test/i2c_line_model.sv]
// Two-wire line model: open-drain SCL and SDA with pull-ups.
`timescale 1ns/1ps
module i2c_line_model (
  // Bench controls
  input wire logic aclk,
  input wire logic sclk_en,
  input wire logic sda_go,
  input wire logic [5:0] sda_len,
  // Lines
  input wire logic scl_oe,
  input wire logic scl_out,
  output logic scl_in,
  output logic sda_in
);
  logic [5:0] left = 6'h00;
  logic ext = 1'b1;
  always @(posedge aclk) begin
    if (sda_go) begin
      left <= sda_len;
    end else if (left != 6'h00) begin
      left <= left - 6'h01;
    end
  end
  // Another master's 160 ns clock, unrelated in phase; idle high.
  initial begin
    #3;
    forever #80 ext = sclk_en ? !ext : 1'b1;
  end
  assign sda_in = (left == 6'h00);
  assign scl_in = ext && !(scl_oe && !scl_out);
endmodule : i2c_line_model

// [test/test_i2c_master_timing_irq.sv]
// Register-level bench for the SCL timing and interrupt mask block.
`timescale 1ns/1ps
module test_i2c_master_timing_irq;
  import i2c_timing_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, sclk_en = 1'b0, sda_go = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [5:0] sda_len = 6'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, scl_in, sda_in, scl_out, scl_oe, irq, lo, p;
  logic scl_filtered, sda_filtered;
  irq_vec_t raw_events = 12'h000;
  int bad_count = 0, num_checks = 0, cyc = 0, n, f;
  int nclk [8] = '{0, 1, 2, 3, 4, 8, 16, 31};
  int per [3] = '{1, 14, 61};
  i2c_master_timing_irq dut (.*);
  i2c_line_model line (.aclk(aclk), .sclk_en(sclk_en), .sda_go(sda_go),
    .sda_len(sda_len), .scl_oe(scl_oe), .scl_out(scl_out),
    .scl_in(scl_in), .sda_in(sda_in));
  always #4 aclk = ~aclk;
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] wd);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task ev(input irq_vec_t v);
    raw_events <= v;
    @(posedge aclk);
    raw_events <= 12'h000;
    repeat (3) @(posedge aclk);
  endtask : ev
  // Lo records whether the filtered SDA level went low after a pulse.
  task pulse(input int len);
    sda_len <= 6'(len);
    sda_go <= 1'b1;
    @(posedge aclk);
    sda_go <= 1'b0;
    lo = 1'b0;
    repeat (len + 40) begin
      @(posedge aclk);
      if (!sda_filtered) lo = 1'b1;
    end
  endtask : pulse
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(TIMER_PERIOD_OFFSET);
    chk("period reset", d, 32'h1);
    rd(MASK_OFFSET);
    chk("mask reset", d, 32'h0);
    wr(TIMER_PERIOD_OFFSET, 32'hFFFFFFFF);
    wr(TIMER_PERIOD_OFFSET, 32'h0);
    rd(TIMER_PERIOD_OFFSET);
    chk("period", d, 32'h0000007F);
    wr(MASK_OFFSET, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'h1;
    wr(MASK_OFFSET, 32'h0);
    s_axi_wstrb <= 4'hF;
    rd(MASK_OFFSET);
    chk("mask", d, 32'hF00);
    rd(8'h40);
    chk("unmapped", 32'(r), 32'(RESP_SLVERR));
    for (int i = 0; i < 12; i++) begin
      wr(MASK_OFFSET, 32'h1 << i);
      ev(irq_vec_t'(~(12'h001 << i)));
      chk("irq masked", 32'(irq), 32'h0);
      ev(irq_vec_t'(12'h001 << i));
      chk("irq", 32'(irq), 32'h1);
      rd(MASKED_OFFSET);
      chk("masked", d, 32'h1 << i);
      rd(STATUS_OFFSET);
      chk("status", d, 32'hFFF);
      repeat (3) @(posedge aclk);
      chk("irq clear", 32'(irq), 32'h0);
    end
    for (int c = 0; c < 8; c++) begin
      wr(TIMER_PERIOD_OFFSET, 32'h1 | (32'(c) << 16));
      n = (nclk[c] > 1) ? nclk[c] : 1;
      if (n > 1) pulse(n - 1);
      if (n > 1) chk("short pulse", 32'(lo), 32'h0);
      pulse(n);
      chk("long pulse", 32'(lo), 32'h1);
    end
    // The last filter code swallows the 80 ns link phases, so bypass it.
    wr(TIMER_PERIOD_OFFSET, 32'h00000001);
    sclk_en <= 1'b1;
    f = 0;
    repeat (100) begin
      p = scl_filtered;
      @(posedge aclk);
      if (p && !scl_filtered) f++;
    end
    sclk_en <= 1'b0;
    chk("link edges", 32'(f >= 4 && f <= 6), 32'h1);
    for (int k = 0; k < 3; k++) begin
      wr(TIMER_PERIOD_OFFSET, 32'(per[k]));
      wr(CONTROL_OFFSET, 32'h1);
      while (!scl_oe) @(posedge aclk);
      for (n = 0; scl_oe; n++) @(posedge aclk);
      chk("scl low", 32'(n), 32'(12 * (1 + per[k])));
      chk("scl drive", 32'(scl_out), 32'h0);
      for (n = 0; !scl_oe; n++) @(posedge aclk);
      chk("scl high", 32'(n), 32'(8 * (1 + per[k])));
      wr(CONTROL_OFFSET, 32'h0);
      repeat (40 * (1 + per[k])) @(posedge aclk);
    end
    end_of_test();
  end
endmodule : test_i2c_master_timing_irq
